/* File: include/cpc_pkg.sv */
// package: constants, types and helpers for the card punch column control
`default_nettype none
package cpc_pkg;
   // clock and documented delays
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned STROBE_DELAY_NS = 15000;
   localparam int unsigned CMD_DELAY_NS = 5000;
   // motor run-on is kept by the punch itself, not counted here
   localparam int unsigned MOTOR_RUNON_S = 30;
   localparam int unsigned STROBE_CYCLES =
      (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CMD_CYCLES =
      (CMD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // widths
   localparam int COL_W = 12;
   localparam int LVL_W = 3;
   localparam int PI_N = 7;
   localparam int ADDR_W = 8;
   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h04;
   // control-out word fields
   localparam int CO_LEVEL = 0;
   localparam int CO_MOTOR = 5;
   localparam int CO_CLR_FLAGS = 6;
   localparam int CO_CD_ENB = 7;
   localparam int CO_EJECT = 12;
   localparam int CO_OFFSET = 14;
   // status-in word fields
   localparam int ST_LEVEL = 0;
   localparam int ST_DATA_REQ = 3;
   localparam int ST_COL_HELD = 4;
   localparam int ST_MOTOR = 5;
   localparam int ST_CARD_DONE = 6;
   localparam int ST_CD_ENB = 7;
   localparam int ST_COMPARE = 8;
   localparam int ST_TROUBLE = 9;
   localparam int ST_PICK = 10;
   localparam int ST_EJECT_F = 11;
   localparam int ST_STACK_F = 12;
   localparam int ST_HOPPER = 13;
   localparam int ST_CHIP = 14;
   localparam int ST_CIP = 15;
   localparam int ST_IRQ = 16;
   localparam int ST_TEST = 17;
   // reset values
   localparam logic [LVL_W-1:0] LEVEL_RST = 3'h0;
   localparam logic [COL_W-1:0] COL_RST = 12'h000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;

   typedef enum logic {CPC_APB_IDLE, CPC_APB_CLEAR} cpc_apb_state_t;

   // one-hot request line for a level; level 0 means no requests
   function automatic logic [PI_N:1] cpc_level_onehot(input logic [LVL_W-1:0] lvl,
                                                      input logic req);
      cpc_level_onehot = '0;
      for (int i = 1; i <= PI_N; i++) begin
         if (req && lvl == LVL_W'(i)) begin
            cpc_level_onehot[i] = 1'b1;
         end
      end
   endfunction
endpackage
`default_nettype wire

/* File: include/cpc_tmr_if.sv */
// interface: start and expiry of a one-shot delay timer
`default_nettype none
interface cpc_tmr_if;
   logic start;
   logic fire;
   logic busy;
   modport ctl (output start, input fire, input busy);
   modport tmr (input start, output fire, output busy);
endinterface
`default_nettype wire

/* File: src/cpc_delay.sv */
// one-shot delay: fire is high in the cycle before the CYCLES-th edge after start
`default_nettype none
module cpc_delay
   import cpc_pkg::*;
#(
   parameter int unsigned CYCLES = CMD_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   cpc_tmr_if.tmr t
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

   logic [CW-1:0] cnt_q;

   // a new start reloads, so a restarted delay counts from the latest start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (t.start) begin
         cnt_q <= LOAD;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign t.fire = (cnt_q == CW'(1)) && !t.start;
   assign t.busy = (cnt_q != '0);
endmodule // cpc_delay
`default_nettype wire

/* File: src/cpc_pi.sv */
// priority interrupt request lines, registered
`default_nettype none
module cpc_pi
   import cpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [LVL_W-1:0] level,
   input wire logic req,
   output logic [PI_N:1] pi_req
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pi_req <= '0;
      end else begin
         pi_req <= cpc_level_onehot(level, req);
      end
   end
endmodule // cpc_pi
`default_nettype wire

/* File: src/cpc_top.sv */
// card punch column control: apb registers, column handshake, punch commands
//
// Notes on behaviour
// - control-out with motor bit sets motor-run, which drives punch_select.
// - once conditioned, punch_ready makes buffer-ready, which sets column request.
// - column request raises the interrupt on the selected priority level.
// - data-out clear phase clears request and buffer; set phase sets column-held.
// - after an eject, data-out set phase also sets motor-run.
// - set phase loads bus data; buffer drives the twelve column lines.
// - data_present_strobe pulses about 15 us after the set phase.
// - column-held clears as the strobe is generated.
// - card_full with card_done_enable set raises card_done_flag and an interrupt.
// - with no eject after column 80 another request follows, columns 81, 82.
// - an eject command also sets card_done_flag.
// - eject bit drives eject_cmd about 5 us later.
// - offset bit drives card_offset_cmd about 5 us later.
// - punch trouble raises an interrupt; pick, eject, stacker failures do not; causes are readable in status.
// - compare error sets compare fault, reported with card done at full or eject.
// - offline test with ready low reads as status bit 18.
// - status bit 32 reads set while requesting a column.
// - control-out bits 33 to 35 set the interrupt level.
// - reset clears every flip-flop and the column buffer.
`default_nettype none
module cpc_top
   import cpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic punch_ready,
   input wire logic card_full,
   input wire logic trouble_in,
   input wire logic pick_failure,
   input wire logic eject_failure,
   input wire logic stacker_failure,
   input wire logic hopper_stacker_in,
   input wire logic chip_box_full_in,
   input wire logic card_in_station,
   input wire logic compare_error_in,
   input wire logic offline_test_in,
   output logic punch_select,
   output logic [COL_W-1:0] column_lines,
   output logic data_present_strobe,
   output logic eject_cmd,
   output logic card_offset_cmd,
   output logic [PI_N:1] pi_req
);
   cpc_apb_state_t apb_q;
   cpc_apb_state_t apb_d;
   logic access;
   logic addr_ok;
   logic ctrl_wr;
   logic data_wr;
   logic data_clr;
   logic data_set;
   logic [31:0] prdata_q;
   logic [31:0] status_word;
   logic [LVL_W-1:0] level_q;
   logic motor_q;
   logic cd_enb_q;
   logic eject_seen_q;
   logic data_req_q;
   logic buf_rdy;
   logic buf_rdy_q;
   logic [COL_W-1:0] col_buf_q;
   logic col_held_q;
   logic strobe_q;
   logic card_done_q;
   logic compare_q;
   logic full_q;
   logic full_rise;
   logic eject_arm_q;
   logic offset_arm_q;
   logic eject_q;
   logic offset_q;
   logic irq_cause;

   cpc_tmr_if strobe_tmr ();
   cpc_tmr_if cmd_tmr ();

   cpc_delay #(.CYCLES(STROBE_CYCLES)) u_strobe_dly (
      .pclk(pclk),
      .presetn(presetn),
      .t(strobe_tmr)
   );

   cpc_delay #(.CYCLES(CMD_CYCLES)) u_cmd_dly (
      .pclk(pclk),
      .presetn(presetn),
      .t(cmd_tmr)
   );

   cpc_pi u_pi (
      .pclk(pclk),
      .presetn(presetn),
      .level(level_q),
      .req(irq_cause),
      .pi_req(pi_req)
   );

   // apb decode
   assign access = psel && penable;
   assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_DATA);
   assign ctrl_wr = access && pwrite && (paddr == ADDR_CTRL);
   assign data_wr = access && pwrite && (paddr == ADDR_DATA);
   // a data-out takes two access cycles: clear phase, then set phase
   assign data_clr = data_wr && (apb_q == CPC_APB_IDLE);
   assign data_set = data_wr && (apb_q == CPC_APB_CLEAR);
   assign pready = !data_clr;
   assign pslverr = access && !addr_ok;
   assign prdata = prdata_q;

   always_comb begin
      apb_d = apb_q;
      unique case (apb_q)
         CPC_APB_IDLE: begin
            if (data_clr) begin
               apb_d = CPC_APB_CLEAR;
            end
         end
         CPC_APB_CLEAR: begin
            apb_d = CPC_APB_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_q <= CPC_APB_IDLE;
      end else begin
         apb_q <= apb_d;
      end
   end

   // status word, sampled in the setup cycle so it holds through the access
   always_comb begin
      status_word = WORD_RST;
      status_word[ST_LEVEL +: LVL_W] = level_q;
      status_word[ST_DATA_REQ] = data_req_q;
      status_word[ST_COL_HELD] = col_held_q;
      status_word[ST_MOTOR] = motor_q;
      status_word[ST_CARD_DONE] = card_done_q;
      status_word[ST_CD_ENB] = cd_enb_q;
      status_word[ST_COMPARE] = compare_q;
      status_word[ST_TROUBLE] = trouble_in;
      status_word[ST_PICK] = pick_failure;
      status_word[ST_EJECT_F] = eject_failure;
      status_word[ST_STACK_F] = stacker_failure;
      status_word[ST_HOPPER] = hopper_stacker_in;
      status_word[ST_CHIP] = chip_box_full_in;
      status_word[ST_CIP] = card_in_station;
      status_word[ST_IRQ] = irq_cause;
      status_word[ST_TEST] = offline_test_in && !punch_ready;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= WORD_RST;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == ADDR_CTRL) begin
            prdata_q <= status_word;
         end else if (paddr == ADDR_DATA) begin
            prdata_q <= {{(32 - COL_W){1'b0}}, col_buf_q};
         end else begin
            prdata_q <= WORD_RST;
         end
      end
   end

   // control-out settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= LEVEL_RST;
         cd_enb_q <= 1'b0;
      end else if (ctrl_wr) begin
         level_q <= pwdata[CO_LEVEL +: LVL_W];
         cd_enb_q <= pwdata[CO_CD_ENB];
      end
   end

   // motor run; the punch itself keeps the motor on 30 s after select drops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         motor_q <= 1'b0;
      end else if (ctrl_wr) begin
         motor_q <= pwdata[CO_MOTOR];
      end else if (data_set && eject_seen_q) begin
         motor_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eject_seen_q <= 1'b0;
      end else if (ctrl_wr && pwdata[CO_EJECT]) begin
         eject_seen_q <= 1'b1;
      end else if (ctrl_wr && !pwdata[CO_MOTOR]) begin
         eject_seen_q <= 1'b0;
      end
   end

   // column request on each new buffer-ready; a held column blocks it
   // the strobe cycle is masked too: the punch drops ready only one edge later
   assign buf_rdy = motor_q && punch_ready && !col_held_q && !strobe_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_rdy_q <= 1'b0;
         data_req_q <= 1'b0;
      end else begin
         buf_rdy_q <= buf_rdy;
         if (buf_rdy && !buf_rdy_q) begin
            data_req_q <= 1'b1;
         end else if (data_clr) begin
            data_req_q <= 1'b0;
         end
      end
   end

   // column buffer and column-held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col_buf_q <= COL_RST;
      end else if (data_clr) begin
         col_buf_q <= COL_RST;
      end else if (data_set) begin
         col_buf_q <= pwdata[COL_W-1:0];
      end
   end

   assign column_lines = col_buf_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         col_held_q <= 1'b0;
      end else if (data_set) begin
         col_held_q <= 1'b1;
      end else if (strobe_tmr.fire) begin
         col_held_q <= 1'b0;
      end
   end

   // strobe timing; the punch picks a card on a card's first strobe
   assign strobe_tmr.start = data_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= strobe_tmr.fire;
      end
   end

   assign data_present_strobe = strobe_q;

   // eject and offset go out one delay after the control-out
   assign cmd_tmr.start = ctrl_wr && (pwdata[CO_EJECT] || pwdata[CO_OFFSET]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eject_arm_q <= 1'b0;
         offset_arm_q <= 1'b0;
         eject_q <= 1'b0;
         offset_q <= 1'b0;
      end else if (ctrl_wr) begin
         eject_arm_q <= pwdata[CO_EJECT];
         offset_arm_q <= pwdata[CO_OFFSET];
         eject_q <= 1'b0;
         offset_q <= 1'b0;
      end else if (cmd_tmr.fire) begin
         eject_q <= eject_arm_q;
         offset_q <= offset_arm_q;
      end
   end

   assign eject_cmd = eject_q;
   assign card_offset_cmd = offset_q;
   assign punch_select = motor_q;

   // card done and compare fault: hardware set wins over software clear
   assign full_rise = card_full && !full_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_q <= 1'b0;
         card_done_q <= 1'b0;
      end else begin
         full_q <= card_full;
         if ((full_rise && cd_enb_q) || (ctrl_wr && pwdata[CO_EJECT])) begin
            card_done_q <= 1'b1;
         end else if (ctrl_wr && pwdata[CO_CLR_FLAGS]) begin
            card_done_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_q <= 1'b0;
      end else if (compare_error_in) begin
         compare_q <= 1'b1;
      end else if (ctrl_wr && pwdata[CO_CLR_FLAGS]) begin
         compare_q <= 1'b0;
      end
   end

   // compare fault alone raises nothing: it is reported with card done
   assign irq_cause = data_req_q || card_done_q || trouble_in;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence dout_s;
      data_clr ##1 data_set;
   endsequence

   sequence eject_wr_s;
      ctrl_wr && pwdata[CO_EJECT];
   endsequence

   motor_on_a: assert property (
      ctrl_wr && pwdata[CO_MOTOR] |=> punch_select)
      else $error("motor bit did not raise punch select");

   req_set_a: assert property (
      buf_rdy && !buf_rdy_q |=> data_req_q ##1 (data_req_q || $past(data_clr)))
      else $error("buffer ready did not set column request");

   pi_level_a: assert property (
      data_req_q && level_q != LEVEL_RST |=> pi_req == cpc_level_onehot($past(level_q), 1'b1))
      else $error("column request not on selected level");

   set_phase_a: assert property (
      dout_s |=> col_held_q && !data_req_q && column_lines == $past(pwdata[COL_W-1:0]))
      else $error("data-out set phase did not load column");

   clr_phase_a: assert property (
      data_clr && !(buf_rdy && !buf_rdy_q) |=> !data_req_q && col_buf_q == COL_RST)
      else $error("clear phase did not clear request and buffer");

   eject_keep_a: assert property (
      data_set && eject_seen_q |=> punch_select)
      else $error("motor not kept on after eject");

   strobe_dly_a: assert property (
      data_set |=> !data_present_strobe ##299 data_present_strobe)
      else $error("strobe not at the documented delay");

   held_clr_a: assert property (
      $rose(data_present_strobe) |-> !col_held_q && $past(col_held_q))
      else $error("column held not cleared with strobe");

   held_busy_a: assert property (
      col_held_q |-> strobe_tmr.busy)
      else $error("column held with no strobe pending");

   cmd_quiet_a: assert property (
      cmd_tmr.busy |-> !eject_cmd && !card_offset_cmd)
      else $error("command output raised before its delay");

   card_done_a: assert property (
      card_full && !full_q && cd_enb_q |=> card_done_q ##1 (pi_req != '0 || level_q == LEVEL_RST))
      else $error("card full did not raise card done");

   eject_flag_a: assert property (
      eject_wr_s |=> card_done_q)
      else $error("eject did not set card done");

   eject_dly_a: assert property (
      eject_wr_s |=> !eject_cmd ##99 (eject_cmd || $past(ctrl_wr)))
      else $error("eject output not at the documented delay");

   offset_dly_a: assert property (
      ctrl_wr && pwdata[CO_OFFSET] |=> !card_offset_cmd ##99
         (card_offset_cmd || $past(ctrl_wr)))
      else $error("offset output not at the documented delay");

   trouble_irq_a: assert property (
      trouble_in && level_q != LEVEL_RST && $stable(level_q) |=> pi_req != '0)
      else $error("trouble did not raise interrupt");

   compare_a: assert property (
      compare_error_in |=> compare_q)
      else $error("compare error not recorded");

   test_bit_a: assert property (
      psel && !penable && !pwrite && paddr == ADDR_CTRL && offline_test_in && !punch_ready
      |=> prdata[ST_TEST])
      else $error("test mode not reported");

   online_req_a: assert property (
      psel && !penable && !pwrite && paddr == ADDR_CTRL |=> prdata[ST_DATA_REQ] == $past(data_req_q))
      else $error("request bit wrong in status");

   irq_drop_a: assert property (
      !data_req_q && !card_done_q && !trouble_in |=> pi_req == '0)
      else $error("interrupt held with no cause");
endmodule // cpc_top
`default_nettype wire

/* File: verif/cpc_punch_model.sv */
// behavioural card punch on the far side of the device cable
`default_nettype none
module cpc_punch_model
   import cpc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic select,
   input wire logic strobe,
   input wire logic eject,
   input wire logic hold_off,
   input wire logic [COL_W-1:0] column,
   output logic ready,
   output logic card_full,
   output logic card_in_station,
   output int n_cols
);
   timeunit 1ns;
   timeprecision 1ns;
   int busy;
   logic [COL_W-1:0] last_col;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready <= 1'b0;
         busy <= 0;
         n_cols <= 0;
         card_full <= 1'b0;
         card_in_station <= 1'b0;
         last_col <= '0;
      end else begin
         if (strobe) begin
            ready <= 1'b0;
            last_col <= column;
            n_cols <= n_cols + 1;
            card_in_station <= 1'b1;
            // four buffered columns take the long punch-and-advance pause
            busy <= ((n_cols + 1) % 4 == 0) ? 40 : 5;
            if (n_cols + 1 == 80) begin
               card_full <= 1'b1;
            end
         end else if (busy > 0) begin
            busy <= busy - 1;
         end else begin
            ready <= select && !hold_off;
         end
         if (eject) begin
            card_full <= 1'b0;
            n_cols <= 0;
            card_in_station <= 1'b0;
         end
      end
   end
endmodule // cpc_punch_model
`default_nettype wire

/* File: verif/cpc_top_test.sv */
// self-checking bench for the card punch column control
`default_nettype none
module cpc_top_test
   import cpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic trouble_in = 1'b0, pick_failure = 1'b0, eject_failure = 1'b0, stacker_failure = 1'b0;
   logic hopper_stacker_in = 1'b0, chip_box_full_in = 1'b0, compare_error_in = 1'b0;
   logic offline_test_in = 1'b0;
   logic punch_ready, card_full, card_in_station, punch_select, data_present_strobe;
   logic eject_cmd, card_offset_cmd;
   logic [COL_W-1:0] column_lines;
   logic [PI_N:1] pi_req;
   int n_fail = 0, checked = 0, cycles = 0, n_cols, n;

   cpc_top cpc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .punch_ready, .card_full, .trouble_in, .pick_failure, .eject_failure,
      .stacker_failure, .hopper_stacker_in, .chip_box_full_in, .card_in_station,
      .compare_error_in, .offline_test_in, .punch_select, .column_lines, .data_present_strobe,
      .eject_cmd, .card_offset_cmd, .pi_req);
   cpc_punch_model cpc_punch_model_inst (.pclk, .presetn, .select(punch_select),
      .strobe(data_present_strobe), .eject(eject_cmd), .hold_off(offline_test_in),
      .column(column_lines), .ready(punch_ready), .card_full, .card_in_station, .n_cols);

   always #(CLK_PERIOD_NS / 2) pclk = ~pclk;

   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a full card of 82 columns needs about 30000 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // entered just after an edge; leaves one idle edge so back-to-back calls never collide
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // 0: any interrupt line, 1: data strobe, 2: eject command; n counts edges
   task automatic wait_hi(input int which, input int lim);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!(which == 0 ? pi_req !== '0 : which == 1 ? data_present_strobe === 1'b1 :
                   eject_cmd === 1'b1) && n < lim);
      if (n >= lim) n_fail++;
   endtask

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd, WORD_RST);
      apb(1'b1, ADDR_CTRL, 32'h0000_00A3); chk(32'(punch_select), 32'h1);
      wait_hi(0, 2000); chk(32'(pi_req), 32'h4);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd, 32'h0001_00AB);
      for (int i = 0; i < 82; i++) begin
         // card done holds the interrupt from column 80 on, so poll for the request itself
         if (i >= 80) begin
            do begin
               apb(1'b0, ADDR_CTRL, 32'h0);
            end while (rd[ST_DATA_REQ] !== 1'b1);
            chk(rd & 32'h0001_0048, 32'h0001_0048);
         end else if (i > 0) begin
            wait_hi(0, 2000);
         end
         apb(1'b1, ADDR_DATA, {20'hFFFFF, 12'(i) ^ 12'hA5C});
         chk(32'(column_lines), 32'(12'(i) ^ 12'hA5C));
         if (i == 0) begin
            apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h0001_0018, 32'h10);
         end
         wait_hi(1, 400);
         if (i == 1) chk(32'(n), 32'(STROBE_CYCLES - 1));
         if (i == 0) begin
            apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h0000_8010, 32'h8000);
            chk(32'(cpc_punch_model_inst.last_col), 32'hA5C);
         end
      end
      apb(1'b1, ADDR_CTRL, 32'h0000_00E3);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h40, 32'h0);
      // eject with the motor bit low: the next data-out set phase restarts the motor
      apb(1'b1, ADDR_CTRL, 32'h0000_5083);
      wait_hi(2, 300); chk(32'(n), 32'(CMD_CYCLES - 1));
      chk(32'(card_offset_cmd), 32'h1);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h60, 32'h40);
      apb(1'b1, ADDR_DATA, 32'h0); chk(32'(punch_select), 32'h1);
      wait_hi(1, 400);
      apb(1'b1, ADDR_CTRL, 32'h0000_0043);
      apb(1'b1, ADDR_DATA, 32'h0);
      wait_hi(1, 400);
      repeat (3) @(posedge pclk);
      chk(32'(pi_req), 32'h0);
      trouble_in <= 1'b1;
      pick_failure <= 1'b1;
      for (int lvl = 1; lvl <= PI_N; lvl++) begin
         apb(1'b1, ADDR_CTRL, 32'(lvl));
         repeat (3) @(posedge pclk);
         chk(32'(pi_req), 32'(1) << (lvl - 1));
      end
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h0001_0600, 32'h0001_0600);
      trouble_in <= 1'b0;
      pick_failure <= 1'b0;
      eject_failure <= 1'b1;
      stacker_failure <= 1'b1;
      hopper_stacker_in <= 1'b1;
      chip_box_full_in <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'(pi_req), 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h7800, 32'h7800);
      eject_failure <= 1'b0;
      stacker_failure <= 1'b0;
      hopper_stacker_in <= 1'b0;
      chip_box_full_in <= 1'b0;
      compare_error_in <= 1'b1;
      @(posedge pclk);
      compare_error_in <= 1'b0;
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h100, 32'h100);
      apb(1'b1, ADDR_CTRL, 32'h0000_0047);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h140, 32'h0);
      offline_test_in <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd & 32'h0002_0000, 32'h0002_0000);
      offline_test_in <= 1'b0;
      apb(1'b0, 8'h08, 32'h0); chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h0000_0023);
      apb(1'b1, ADDR_DATA, 32'h0000_0FFF);
      presetn <= 1'b0;
      @(posedge pclk);
      chk(32'({punch_select, column_lines}), 32'h0);
      repeat (19) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_CTRL, 32'h0); chk(rd, WORD_RST);
      end_of_test();
   end
endmodule // cpc_top_test
`default_nettype wire
